// ==== pkg/asw_pkg.sv ====
`default_nettype none
package asw_pkg;
    localparam int NUM_CH = 6;
    localparam int WORD_W = 24;
    localparam int MAP_W = 24;
    localparam int ENTRY_W = 4;
    localparam int RATE_W = 4;
    localparam int PD_W = 2;
    localparam int MODE_W = 3;
    // bit positions inside the status word
    localparam int POS_RDY = 0;
    localparam int POS_MODULATOR_SATURATION = 1;
    localparam int POS_PD_LO = 2;
    localparam int POS_RATE_LO = 4;
    localparam int POS_DOR = 9;
    localparam int POS_SERR = 15;
    localparam int POS_SCAN_RESULT_READY_LO = 16;
    localparam int POS_INRST = 22;
    // scan mode range bounds, forbidden channel numbers and reset values
    localparam logic [2:0] MODE_SCAN_LO = 3'h2;
    localparam logic [2:0] MODE_SCAN_HI = 3'h4;
    localparam logic [2:0] CH_BAD_A = 3'h6;
    localparam logic [2:0] CH_BAD_B = 3'h7;
    localparam logic [NUM_CH-1:0] SCAN_RESULT_READY_RST = 6'h00;
    localparam logic [RATE_W-1:0] RATE_RST = 4'h0;
    localparam logic [PD_W-1:0] PD_RST = 2'h0;

    // result landing in the result store
    typedef struct packed {
        logic valid;
        logic [MODE_W-1:0] chan;
        logic [RATE_W-1:0] rate;
        logic clipped;
    } asw_result_s;

    typedef struct packed {
        logic [NUM_CH-1:0] scan_result_ready;
        logic serr;
        logic digital_overrange;
        logic [RATE_W-1:0] rate;
        logic [PD_W-1:0] pd;
        logic modulator_saturation;
        logic rdy;
        logic inrst;
        logic [WORD_W-1:0] word;
        logic conv_go;
        logic conv_abort;
    } asw_state_s;
endpackage
`default_nettype wire

// ==== hw/asw_status.sv ====
// How it works
// (R1) scan modes 2-4: set channel ready bit (21:16) when its result arrives
// (R2) completed read of a channel's result clears that channel's ready bit
// (R3) start of a scan mode clears all ready bits
// (R4) scan error bit 15 set when scan mode on and no channel enabled
// (R5) scan error also set when an enabled map entry selects channel 6 or 7
// (R6) conversion commands aborted while scan error set; accepted after clear
// (R7) power-down field, saturation and data-ready bits read-only, reset zero
// (R8) rate field 7:4 shows current result's rate, valid until it is read
// (R9) digital overrange bit 9 set when a result was clipped
// (R10) new result in same cycle as completing read keeps ready bit set
`timescale 1ns/10ps
`default_nettype none
module asw_status
    import asw_pkg::*;
(
    // clock and reset
    input wire logic SYS_CLK,
    input wire logic RESET_N,
    // sequencer configuration
    input wire logic [asw_pkg::MODE_W-1:0] SEQ_MODE,
    input wire logic SCAN_START,
    input wire logic [asw_pkg::MAP_W-1:0] CH_MAP_FIRST,
    input wire logic [asw_pkg::MAP_W-1:0] CH_MAP_SECOND,
    // results and reads
    input wire asw_pkg::asw_result_s RESULT,
    input wire logic READ_DONE,
    input wire logic [asw_pkg::MODE_W-1:0] READ_CHAN,
    // core status inputs
    input wire logic [asw_pkg::PD_W-1:0] POWER_DOWN_STATE,
    input wire logic MODULATOR_SATURATION,
    input wire logic DATA_READY,
    input wire logic RESET_IN_PROGRESS,
    // conversion command
    input wire logic CONV_CMD,
    output logic CONV_GO,
    output logic CONV_ABORT,
    // status word
    output logic [asw_pkg::WORD_W-1:0] CONVERTER_STATUS_WORD
);
    import asw_pkg::*;

    asw_state_s st_ff;
    asw_state_s nxt_st;

    function automatic logic scan_mode(input logic [MODE_W-1:0] m);
        scan_mode = (m >= MODE_SCAN_LO) && (m <= MODE_SCAN_HI);
    endfunction

    // map entry: enable at top bit, channel number in low bits
    function automatic logic [1:0] map_check(input logic [MAP_W-1:0] map);
        logic any_en;
        logic bad;
        logic [ENTRY_W-1:0] e;
        any_en = 1'b0;
        bad = 1'b0;
        for (int i = 0; i < MAP_W / ENTRY_W; i++) begin
            e = map[i*ENTRY_W +: ENTRY_W];
            if (e[ENTRY_W-1]) begin
                any_en = 1'b1;
                if (e[ENTRY_W-2:0] == CH_BAD_A || e[ENTRY_W-2:0] == CH_BAD_B) begin
                    bad = 1'b1;
                end
            end
        end
        map_check = {any_en, bad};
    endfunction

    logic [1:0] chk_a;
    logic [1:0] chk_b;
    logic scan_err;
    logic [NUM_CH-1:0] set_v;
    logic [NUM_CH-1:0] clr_v;

    always_comb begin
        chk_a = map_check(CH_MAP_FIRST);
        chk_b = map_check(CH_MAP_SECOND);
        // error is a live view of configuration so it clears as soon as it is fixed
        scan_err = scan_mode(SEQ_MODE) &&
                   ((!chk_a[1] && !chk_b[1]) || chk_a[0] || chk_b[0]); // R4 R5
        set_v = '0;
        clr_v = '0;
        if (RESULT.valid && scan_mode(SEQ_MODE) && RESULT.chan < MODE_W'(NUM_CH)) begin
            set_v[RESULT.chan] = 1'b1; // R1
        end
        if (READ_DONE && READ_CHAN < MODE_W'(NUM_CH)) begin
            clr_v[READ_CHAN] = 1'b1; // R2
        end
        nxt_st = st_ff;
        nxt_st.scan_result_ready = (st_ff.scan_result_ready & ~clr_v) | set_v; // R10
        if (SCAN_START) begin
            nxt_st.scan_result_ready = SCAN_RESULT_READY_RST | set_v; // R3
        end
        nxt_st.serr = scan_err; // R4
        if (RESULT.valid) begin
            nxt_st.rate = RESULT.rate; // R8
            nxt_st.digital_overrange = RESULT.clipped; // R9
        end else if (READ_DONE) begin
            nxt_st.rate = RATE_RST; // R8
        end
        nxt_st.pd = POWER_DOWN_STATE; // R7
        nxt_st.modulator_saturation = MODULATOR_SATURATION; // R7
        nxt_st.rdy = DATA_READY; // R7
        nxt_st.inrst = RESET_IN_PROGRESS;
        nxt_st.conv_go = CONV_CMD && !scan_err; // R6
        nxt_st.conv_abort = CONV_CMD && scan_err; // R6
        nxt_st.word = '0;
        nxt_st.word[POS_SCAN_RESULT_READY_LO +: NUM_CH] = nxt_st.scan_result_ready;
        nxt_st.word[POS_INRST] = nxt_st.inrst;
        nxt_st.word[POS_SERR] = nxt_st.serr;
        nxt_st.word[POS_DOR] = nxt_st.digital_overrange;
        nxt_st.word[POS_RATE_LO +: RATE_W] = nxt_st.rate;
        nxt_st.word[POS_PD_LO +: PD_W] = nxt_st.pd;
        nxt_st.word[POS_MODULATOR_SATURATION] = nxt_st.modulator_saturation;
        nxt_st.word[POS_RDY] = nxt_st.rdy;
    end

    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            st_ff <= '0; // R7
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign CONV_GO = st_ff.conv_go;
    assign CONV_ABORT = st_ff.conv_abort;
    assign CONVERTER_STATUS_WORD = st_ff.word;

    a_set_on_result: assert property (@(posedge SYS_CLK) disable iff (!RESET_N) // R1
        RESULT.valid && scan_mode(SEQ_MODE) && RESULT.chan < MODE_W'(NUM_CH)
        |=> CONVERTER_STATUS_WORD[POS_SCAN_RESULT_READY_LO + $past(RESULT.chan)])
        else $error("ready bit not set after result");
    a_clear_on_read: assert property (@(posedge SYS_CLK) disable iff (!RESET_N) // R2
        READ_DONE && READ_CHAN < MODE_W'(NUM_CH) && !RESULT.valid
        |=> !CONVERTER_STATUS_WORD[POS_SCAN_RESULT_READY_LO + $past(READ_CHAN)])
        else $error("ready bit not cleared by read");
    a_scan_start_clr: assert property (@(posedge SYS_CLK) disable iff (!RESET_N) // R3
        SCAN_START && !RESULT.valid |=> CONVERTER_STATUS_WORD[POS_SCAN_RESULT_READY_LO +: NUM_CH] == '0)
        else $error("ready bits not cleared at scan start");
    // RESET_N in front keeps the release edge out: the flops are still held clear there
    a_no_chan_err: assert property (@(posedge SYS_CLK) disable iff (!RESET_N) // R4
        RESET_N && scan_mode(SEQ_MODE) && !chk_a[1] && !chk_b[1]
        |=> CONVERTER_STATUS_WORD[POS_SERR])
        else $error("scan error missing with empty maps");
    a_bad_chan_err: assert property (@(posedge SYS_CLK) disable iff (!RESET_N) // R5
        RESET_N && scan_mode(SEQ_MODE) && (chk_a[0] || chk_b[0])
        |=> CONVERTER_STATUS_WORD[POS_SERR])
        else $error("scan error missing with bad channel");
    a_abort_on_err: assert property (@(posedge SYS_CLK) disable iff (!RESET_N) // R6
        RESET_N && CONV_CMD ##1 CONVERTER_STATUS_WORD[POS_SERR] |-> CONV_ABORT && !CONV_GO)
        else $error("conversion not aborted under scan error");
    a_low_bits_follow: assert property (@(posedge SYS_CLK) disable iff (!RESET_N) // R7
        RESET_N |=> CONVERTER_STATUS_WORD[POS_PD_LO +: PD_W] == $past(POWER_DOWN_STATE))
        else $error("power-down field wrong");
    a_rate_capture: assert property (@(posedge SYS_CLK) disable iff (!RESET_N) // R8
        RESULT.valid |=> CONVERTER_STATUS_WORD[POS_RATE_LO +: RATE_W] == $past(RESULT.rate))
        else $error("rate field wrong");
    a_overrange: assert property (@(posedge SYS_CLK) disable iff (!RESET_N) // R9
        RESULT.valid && RESULT.clipped |=> CONVERTER_STATUS_WORD[POS_DOR])
        else $error("overrange bit not set");
    a_set_beats_clr: assert property (@(posedge SYS_CLK) disable iff (!RESET_N) // R10
        RESULT.valid && scan_mode(SEQ_MODE) && READ_DONE && READ_CHAN == RESULT.chan
        && RESULT.chan < MODE_W'(NUM_CH)
        |=> CONVERTER_STATUS_WORD[POS_SCAN_RESULT_READY_LO + $past(READ_CHAN)])
        else $error("ready bit lost on simultaneous read");

    a_scan_result_ready_hold: assert property (@(posedge SYS_CLK) disable iff (!RESET_N) // R2
        RESET_N && !RESULT.valid && !READ_DONE && !SCAN_START
        |=> $stable(CONVERTER_STATUS_WORD[POS_SCAN_RESULT_READY_LO +: NUM_CH]))
        else $error("ready bits moved without cause");
    a_no_set_idle: assert property (@(posedge SYS_CLK) disable iff (!RESET_N) // R1
        RESET_N && RESULT.valid && !scan_mode(SEQ_MODE) && !READ_DONE && !SCAN_START
        |=> $stable(CONVERTER_STATUS_WORD[POS_SCAN_RESULT_READY_LO +: NUM_CH]))
        else $error("ready bit set outside scan modes");
    a_bad_result_chan: assert property (@(posedge SYS_CLK) disable iff (!RESET_N) // R1
        RESET_N && RESULT.valid && RESULT.chan >= MODE_W'(NUM_CH) && !READ_DONE && !SCAN_START
        |=> $stable(CONVERTER_STATUS_WORD[POS_SCAN_RESULT_READY_LO +: NUM_CH]))
        else $error("ready bits moved for missing channel");
    a_start_keeps_new: assert property (@(posedge SYS_CLK) disable iff (!RESET_N) // R3
        SCAN_START && RESULT.valid && scan_mode(SEQ_MODE) && RESULT.chan < MODE_W'(NUM_CH)
        |=> $onehot(CONVERTER_STATUS_WORD[POS_SCAN_RESULT_READY_LO +: NUM_CH])
        && CONVERTER_STATUS_WORD[POS_SCAN_RESULT_READY_LO + $past(RESULT.chan)])
        else $error("scan start kept stale or lost new ready bit");

    a_serr_off: assert property (@(posedge SYS_CLK) disable iff (!RESET_N) // R4
        !scan_mode(SEQ_MODE) |=> !CONVERTER_STATUS_WORD[POS_SERR])
        else $error("scan error outside scan modes");
    a_serr_clean_cfg: assert property (@(posedge SYS_CLK) disable iff (!RESET_N) // R5
        scan_mode(SEQ_MODE) && (chk_a[1] || chk_b[1]) && !chk_a[0] && !chk_b[0]
        |=> !CONVERTER_STATUS_WORD[POS_SERR])
        else $error("scan error with sound maps");

    a_go_no_err: assert property (@(posedge SYS_CLK) disable iff (!RESET_N) // R6
        RESET_N && CONV_CMD ##1 !CONVERTER_STATUS_WORD[POS_SERR]
        |-> CONV_GO && !CONV_ABORT)
        else $error("conversion refused without scan error");
    a_no_cmd_quiet: assert property (@(posedge SYS_CLK) disable iff (!RESET_N) // R6
        !CONV_CMD |=> !CONV_GO && !CONV_ABORT)
        else $error("conversion outcome without command");

    // no disable here: this one is about reset itself
    a_reset_clear: assert property (@(posedge SYS_CLK) // R7
        !RESET_N |-> CONVERTER_STATUS_WORD == '0 && !CONV_GO && !CONV_ABORT)
        else $error("outputs not cleared in reset");
    a_sat_follow: assert property (@(posedge SYS_CLK) disable iff (!RESET_N) // R7
        RESET_N |=> CONVERTER_STATUS_WORD[POS_MODULATOR_SATURATION] == $past(MODULATOR_SATURATION))
        else $error("saturation bit wrong");
    a_ready_follow: assert property (@(posedge SYS_CLK) disable iff (!RESET_N) // R7
        RESET_N |=> CONVERTER_STATUS_WORD[POS_RDY] == $past(DATA_READY))
        else $error("data-ready bit wrong");

    a_rate_clear: assert property (@(posedge SYS_CLK) disable iff (!RESET_N) // R8
        READ_DONE && !RESULT.valid |=> CONVERTER_STATUS_WORD[POS_RATE_LO +: RATE_W] == RATE_RST)
        else $error("rate field kept after read");
    a_rate_hold: assert property (@(posedge SYS_CLK) disable iff (!RESET_N) // R8
        RESET_N && !READ_DONE && !RESULT.valid
        |=> $stable(CONVERTER_STATUS_WORD[POS_RATE_LO +: RATE_W]))
        else $error("rate field moved without cause");
    a_dor_clear: assert property (@(posedge SYS_CLK) disable iff (!RESET_N) // R9
        RESULT.valid && !RESULT.clipped |=> !CONVERTER_STATUS_WORD[POS_DOR])
        else $error("overrange bit kept on clean result");
    a_dor_hold: assert property (@(posedge SYS_CLK) disable iff (!RESET_N) // R9
        RESET_N && !RESULT.valid |=> $stable(CONVERTER_STATUS_WORD[POS_DOR]))
        else $error("overrange bit moved without result");
endmodule
`default_nettype wire

// ==== verif/asw_host_model.sv ====
`timescale 1ns/10ps
`default_nettype none
// host side: finishes a full result read one cycle after it is asked to
module asw_host_model
    import asw_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // read request and completion
    input wire logic rd_req,
    input wire logic [MODE_W-1:0] rd_sel,
    output logic rd_done,
    output logic [MODE_W-1:0] rd_chan
);
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_done <= 1'b0;
            rd_chan <= 3'h0;
        end else begin
            rd_done <= rd_req;
            // idle select flips each cycle so a stale channel number is never held while rd_done is low
            rd_chan <= rd_req ? rd_sel : ~rd_chan;
        end
    end
endmodule
`default_nettype wire

// ==== verif/asw_status_test.sv ====
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, a) begin checks++; if ((a) !== (e)) begin fails++; $display("[ERR] %s exp %h got %h", n, e, a); end end
module asw_status_test;
    import asw_pkg::*;
    logic sys_clk, reset_n, scan_start, conv_cmd, rd_req, rd_done, modulator_saturation, drdy, inrst, go, abort;
    logic [MODE_W-1:0] seq_mode, rd_sel, rd_chan;
    logic [MAP_W-1:0] map_a, map_b;
    logic [PD_W-1:0] pd;
    logic [WORD_W-1:0] word;
    asw_result_s res;
    int fails = 0;
    int checks = 0;
    localparam logic [3:0] p_scan = 4'h8;
    localparam logic [3:0] p_conv = 4'h4;
    localparam logic [3:0] p_read = 4'h2;
    localparam logic [3:0] p_res = 4'h1;
    asw_status asw_status_i (.SYS_CLK(sys_clk), .RESET_N(reset_n), .SEQ_MODE(seq_mode),
        .SCAN_START(scan_start), .CH_MAP_FIRST(map_a), .CH_MAP_SECOND(map_b), .RESULT(res),
        .READ_DONE(rd_done), .READ_CHAN(rd_chan), .POWER_DOWN_STATE(pd),
        .MODULATOR_SATURATION(modulator_saturation), .DATA_READY(drdy), .RESET_IN_PROGRESS(inrst),
        .CONV_CMD(conv_cmd), .CONV_GO(go), .CONV_ABORT(abort), .CONVERTER_STATUS_WORD(word));
    asw_host_model asw_host_model_i (.clk(sys_clk), .rst_n(reset_n), .rd_req(rd_req),
        .rd_sel(rd_sel), .rd_done(rd_done), .rd_chan(rd_chan));
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    // all four pulses are written once per edge, so none is driven twice in a step
    task automatic cyc(int n = 1, logic [3:0] p = 4'h0);
        repeat (n) begin
            @(posedge sys_clk);
            {scan_start, conv_cmd, rd_req, res.valid} <= p;
            p = 4'h0;
        end
    endtask
    task automatic put(logic [2:0] ch, logic [3:0] rt, logic clip);
        res.chan <= ch;
        res.rate <= rt;
        res.clipped <= clip;
    endtask
    task automatic end_sim();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        #4000;
        fails++;
        end_sim();
    end
    initial begin
        {reset_n, scan_start, conv_cmd, rd_req, rd_sel, map_b, res} <= '0;
        {seq_mode, map_a, pd, modulator_saturation, drdy, inrst} <= {3'h2, 24'h00000a, 2'h3, 3'h7};
        cyc(4);
        #1 `CHK("word", 24'h0, word)
        cyc();
        reset_n <= 1'b1;
        cyc();
        cyc(1, p_scan);
        #1 `CHK("word", 24'h40000f, word)
        cyc(1, p_res);
        put(3'h2, 4'h5, 1'b1);
        cyc(1, p_read);
        rd_sel <= 3'h2;
        #1 `CHK("scan_result_ready", 6'h04, word[21:16])
        `CHK("rate", 4'h5, word[7:4])
        `CHK("dor", 1'b1, word[9])
        // the new result lands on the same edge as the read of the old one
        cyc(1, p_res);
        put(3'h2, 4'h6, 1'b0);
        cyc(1, p_read);
        #1 `CHK("scan_result_ready", 6'h04, word[21:16])
        `CHK("dor", 1'b0, word[9])
        `CHK("rate", 4'h6, word[7:4])
        cyc();
        cyc(1, p_res);
        put(3'h5, 4'h1, 1'b0);
        #1 `CHK("scan_result_ready", 6'h00, word[21:16])
        `CHK("rate", 4'h0, word[7:4])
        cyc(1, p_scan);
        #1 `CHK("scan_result_ready", 6'h20, word[21:16])
        cyc(1, p_res);
        seq_mode <= 3'h1;
        put(3'h4, 4'h1, 1'b0);
        #1 `CHK("scan_result_ready", 6'h00, word[21:16])
        cyc(1, p_conv);
        seq_mode <= 3'h2;
        #1 `CHK("scan_result_ready", 6'h00, word[21:16])
        cyc(1, p_conv);
        map_a <= 24'h0;
        #1 `CHK("go", 2'h2, {go, abort})
        cyc();
        #1 `CHK("serr", 1'b1, word[15])
        `CHK("abort", 2'h1, {go, abort})
        for (int i = 6; i < 8; i++) begin
            cyc();
            map_a <= 24'h00000a;
            map_b <= {20'h0, 1'b1, i[2:0]};
            cyc();
            #1 `CHK("serr", 1'b1, word[15])
        end
        cyc(1, p_conv);
        map_b <= 24'h0;
        cyc();
        #1 `CHK("go", 3'h4, {go, abort, word[15]})
        end_sim();
    end
endmodule
`default_nettype wire
